/* src/adc_ctl_pkg.sv */
package adc_ctl_pkg;

	// Clock
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 50;

	// Channels and modes
	localparam int        NUM_CH    = 9;
	localparam int        CH_W      = 4;
	localparam logic [8:0] DUAL_MASK = 9'h064;
	localparam logic [2:0] MODE_MAX  = 3'h4;
	localparam logic [1:0] RANGE_BAD = 2'h3;
	localparam int        SMP_W     = 16;
	localparam int        CNT_W     = 12;

	// Conversion time, longest, rounded down
	localparam int CONV_NS  = 10_000;
	localparam int CONV_CYC = CONV_NS / CLK_NS;

	// Settling after channel switch, least, rounded up
	localparam int LAT_US_M0  = 171;
	localparam int LAT_US_M1  = 85;
	localparam int LAT_US_M2  = 21;
	localparam int LAT_US_M3  = 11;
	localparam int LAT_US_M4  = 5;
	localparam int LAT_CYC_M0 = (LAT_US_M0 * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int LAT_CYC_M1 = (LAT_US_M1 * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int LAT_CYC_M2 = (LAT_US_M2 * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int LAT_CYC_M3 = (LAT_US_M3 * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int LAT_CYC_M4 = (LAT_US_M4 * 1000 + CLK_NS - 1) / CLK_NS;

	// Maximum sample rates in Hz, period rounded up
	localparam int RATE_HZ_M0 = 5859;
	localparam int RATE_HZ_M1 = 11700;
	localparam int RATE_HZ_M2 = 46875;
	localparam int RATE_HZ_M3 = 93750;
	localparam int RATE_HZ_M4 = 187000;
	localparam int PER_CYC_M0 = (CLK_HZ + RATE_HZ_M0 - 1) / RATE_HZ_M0;
	localparam int PER_CYC_M1 = (CLK_HZ + RATE_HZ_M1 - 1) / RATE_HZ_M1;
	localparam int PER_CYC_M2 = (CLK_HZ + RATE_HZ_M2 - 1) / RATE_HZ_M2;
	localparam int PER_CYC_M3 = (CLK_HZ + RATE_HZ_M3 - 1) / RATE_HZ_M3;
	localparam int PER_CYC_M4 = (CLK_HZ + RATE_HZ_M4 - 1) / RATE_HZ_M4;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_CFG   = 8'h04;
	localparam logic [7:0] OFF_STAT  = 8'h08;
	localparam logic [7:0] OFF_DATA  = 8'h0C;
	localparam logic [7:0] OFF_ISTAT = 8'h10;
	localparam logic [7:0] OFF_IMASK = 8'h14;
	localparam logic [7:0] OFF_OFFS  = 8'h18;

	// Fields
	localparam int CTRL_START = 0;
	localparam int CTRL_CONT  = 1;
	localparam int CFG_CH_LSB = 0;
	localparam int CFG_ALT    = 4;
	localparam int CFG_RG_LSB = 5;
	localparam int CFG_REF    = 7;
	localparam int CFG_MD_LSB = 8;
	localparam int CFG_W      = 11;
	localparam int IRQ_W      = 4;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_OVR    = 1;
	localparam int IRQ_TMO    = 2;
	localparam int IRQ_CFG    = 3;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_SETTLE = 5'h02,
		ST_CONV   = 5'h04,
		ST_PROC   = 5'h08,
		ST_PACE   = 5'h10
	} state_e;

	function automatic logic [CNT_W-1:0] lat_cyc(input logic [2:0] m);
		case (m)
			3'h0:    lat_cyc = CNT_W'(LAT_CYC_M0);
			3'h1:    lat_cyc = CNT_W'(LAT_CYC_M1);
			3'h2:    lat_cyc = CNT_W'(LAT_CYC_M2);
			3'h3:    lat_cyc = CNT_W'(LAT_CYC_M3);
			default: lat_cyc = CNT_W'(LAT_CYC_M4);
		endcase
	endfunction : lat_cyc

	function automatic logic [CNT_W-1:0] per_cyc(input logic [2:0] m);
		case (m)
			3'h0:    per_cyc = CNT_W'(PER_CYC_M0);
			3'h1:    per_cyc = CNT_W'(PER_CYC_M1);
			3'h2:    per_cyc = CNT_W'(PER_CYC_M2);
			3'h3:    per_cyc = CNT_W'(PER_CYC_M3);
			default: per_cyc = CNT_W'(PER_CYC_M4);
		endcase
	endfunction : per_cyc

endpackage : adc_ctl_pkg

/* src/adc_proc_if.sv */
`timescale 1ns/100ps
interface adc_proc_if;
	logic [15:0] raw;
	logic        raw_valid;
	logic [15:0] offset;
	logic [15:0] sample;
	logic        sample_valid;

	modport ctl  (output raw, raw_valid, offset, input sample, sample_valid);
	modport proc (input raw, raw_valid, offset, output sample, sample_valid);
endinterface : adc_proc_if

/* src/adc_sample_proc.sv */
`timescale 1ns/100ps
module adc_sample_proc (
	// Clock and reset
	input wire logic   pclk,
	input wire logic   presetn,
	// Sample path
	adc_proc_if.proc   pif
);
	logic [16:0] diff;
	logic [15:0] nxt_sample;
	logic [15:0] sample_ff;
	logic        valid_ff;

	// Offset removal, saturating at zero so a low reading never wraps
	assign diff       = {1'b0, pif.raw} - {1'b0, pif.offset};
	assign nxt_sample = diff[16] ? 16'h0000 : diff[15:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_ff <= 16'h0000;
			valid_ff  <= 1'b0;
		end else begin
			valid_ff <= pif.raw_valid;
			if (pif.raw_valid) begin
				sample_ff <= nxt_sample;
			end
		end
	end

	assign pif.sample       = sample_ff;
	assign pif.sample_valid = valid_ff;
endmodule : adc_sample_proc

/* src/adc_down_timer.sv */
`timescale 1ns/100ps
module adc_down_timer #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// Control
	input wire logic         load,
	input wire logic [W-1:0] load_val,
	output logic             expired
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	assign nxt_cnt = load ? load_val : ((cnt_ff == '0) ? cnt_ff : cnt_ff - 1'b1);
	assign expired = (cnt_ff == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : adc_down_timer

/* src/adc_digital_control.sv */
// Operation
// - Each result is delivered as a 16-bit sample word.
// - Nine input channels; only the selected one is converted.
// - A conversion completes within 10 us of its start.
// - Reference selectable between supply-based and bandgap-based.
// - Raw core output is processed into valid samples for firmware.
// - Logic drives the input and reference multiplexer selections.
// - Input range is 0-3.6 V, 0-2.4 V or 0-1.2 V.
// - Five modes, each with its own maximum sample rate; the logic paces only continuous starts, firmware starts are not rate-limited.
// - After a channel switch wait the mode's settling latency first.
`timescale 1ns/100ps
module adc_digital_control (
	// APB slave
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [7:0]   paddr,
	input wire logic [31:0]  pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq,
	// Analog core
	output logic [3:0]       core_chan_sel,
	output logic             core_pin_alt,
	output logic [1:0]       core_range,
	output logic             core_ref_bandgap,
	output logic [2:0]       core_mode,
	output logic             core_start,
	input wire logic         core_done,
	input wire logic [15:0]  core_raw
);
	localparam int CONV_LIM = adc_ctl_pkg::CONV_CYC + 3;

	adc_ctl_pkg::state_e state_ff, nxt_state;

	logic [31:0] prdata_ff, rd_mux;
	logic        pready_ff, pslverr_ff, irq_ff;
	logic [adc_ctl_pkg::CFG_W-1:0] cfg_ff;
	logic        cont_ff, valid_ff, unread_ff;
	logic [15:0] offs_ff, data_ff;
	logic [adc_ctl_pkg::IRQ_W-1:0] istat_ff, imask_ff, ev, w1c;
	logic [3:0]  cur_chan_ff;
	logic        cur_alt_ff, cur_ref_ff, chan_known_ff, core_start_ff;
	logic [1:0]  cur_range_ff;
	logic [2:0]  cur_mode_ff;
	logic [adc_ctl_pkg::CNT_W-1:0] gap_ff, tmr_val;
	logic        done_s1_ff, done_s2_ff, done_d_ff;
	logic [15:0] raw_s1_ff, raw_s2_ff;
	logic        tmr_load, tmr_exp;

	adc_proc_if pif ();

	adc_sample_proc u_proc (
		.pclk    (pclk),
		.presetn (presetn),
		.pif     (pif.proc)
	);

	adc_down_timer #(.W(adc_ctl_pkg::CNT_W)) u_tmr (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_exp)
	);

	// Bus decode
	wire setup   = psel & ~penable & ~pready_ff;
	wire access  = psel & penable & pready_ff;
	wire wr      = access & pwrite;
	wire rd      = access & ~pwrite;
	wire h_ctrl  = (paddr == adc_ctl_pkg::OFF_CTRL);
	wire h_cfg   = (paddr == adc_ctl_pkg::OFF_CFG);
	wire h_stat  = (paddr == adc_ctl_pkg::OFF_STAT);
	wire h_data  = (paddr == adc_ctl_pkg::OFF_DATA);
	wire h_istat = (paddr == adc_ctl_pkg::OFF_ISTAT);
	wire h_imask = (paddr == adc_ctl_pkg::OFF_IMASK);
	wire h_offs  = (paddr == adc_ctl_pkg::OFF_OFFS);
	wire mapped  = h_ctrl | h_cfg | h_stat | h_data | h_istat | h_imask | h_offs;

	// Config fields
	wire [3:0] cfg_chan  = cfg_ff[adc_ctl_pkg::CFG_CH_LSB +: 4];
	wire [1:0] cfg_range = cfg_ff[adc_ctl_pkg::CFG_RG_LSB +: 2];
	wire [2:0] cfg_mode  = cfg_ff[adc_ctl_pkg::CFG_MD_LSB +: 3];
	wire       cfg_ok    = (cfg_chan < 4'(adc_ctl_pkg::NUM_CH)) && (cfg_mode <= adc_ctl_pkg::MODE_MAX)
	                       && (cfg_range != adc_ctl_pkg::RANGE_BAD);
	wire       ch_switch = !chan_known_ff || (cfg_chan != cur_chan_ff) || (cfg_ff[adc_ctl_pkg::CFG_ALT] != cur_alt_ff);

	// Start requests: firmware write, or continuous pacing at the mode's rate
	wire sw_start  = wr & h_ctrl & pwdata[adc_ctl_pkg::CTRL_START];
	wire pace_done = (gap_ff >= adc_ctl_pkg::per_cyc(cur_mode_ff));
	wire go        = ((state_ff == adc_ctl_pkg::ST_IDLE) & sw_start)
	                 | ((state_ff == adc_ctl_pkg::ST_PACE) & cont_ff & pace_done);
	wire launch    = go & cfg_ok;
	wire done_rise = done_s2_ff & ~done_d_ff;
	wire conv_tmo  = (state_ff == adc_ctl_pkg::ST_CONV) & tmr_exp & ~done_rise & ~core_start_ff;
	wire result    = (state_ff == adc_ctl_pkg::ST_PROC) & pif.sample_valid;
	wire enter_cv  = (nxt_state == adc_ctl_pkg::ST_CONV) & (state_ff != adc_ctl_pkg::ST_CONV);
	wire data_rd   = rd & h_data;

	// Sample path to processing stage
	assign pif.raw       = raw_s2_ff;
	assign pif.raw_valid = (state_ff == adc_ctl_pkg::ST_CONV) & done_rise & ~core_start_ff;
	assign pif.offset    = offs_ff;

	assign tmr_load = launch | enter_cv;
	assign tmr_val  = enter_cv ? adc_ctl_pkg::CNT_W'(adc_ctl_pkg::CONV_CYC)
	                           : adc_ctl_pkg::lat_cyc(cfg_mode);

	assign ev[adc_ctl_pkg::IRQ_DONE] = result;
	assign ev[adc_ctl_pkg::IRQ_OVR]  = result & unread_ff & ~data_rd;
	assign ev[adc_ctl_pkg::IRQ_TMO]  = conv_tmo;
	assign ev[adc_ctl_pkg::IRQ_CFG]  = go & ~cfg_ok;
	assign w1c = (wr & h_istat) ? pwdata[adc_ctl_pkg::IRQ_W-1:0] : '0;

	assign rd_mux = h_ctrl  ? {30'h0, cont_ff, 1'b0} :
	                h_cfg   ? {21'h0, cfg_ff} :
	                h_stat  ? {24'h0, cur_chan_ff, state_ff == adc_ctl_pkg::ST_CONV,
	                           state_ff == adc_ctl_pkg::ST_SETTLE, state_ff != adc_ctl_pkg::ST_IDLE, valid_ff} :
	                h_data  ? {16'h0, data_ff} :
	                h_istat ? {28'h0, istat_ff} :
	                h_imask ? {28'h0, imask_ff} :
	                h_offs  ? {16'h0, offs_ff} : 32'h0000_0000;

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			adc_ctl_pkg::ST_IDLE: begin
				if (launch) begin
					nxt_state = ch_switch ? adc_ctl_pkg::ST_SETTLE : adc_ctl_pkg::ST_CONV;
				end
			end
			adc_ctl_pkg::ST_SETTLE: begin
				if (tmr_exp) begin
					nxt_state = adc_ctl_pkg::ST_CONV;
				end
			end
			adc_ctl_pkg::ST_CONV: begin
				if (pif.raw_valid) begin
					nxt_state = adc_ctl_pkg::ST_PROC;
				end else if (conv_tmo) begin
					nxt_state = cont_ff ? adc_ctl_pkg::ST_PACE : adc_ctl_pkg::ST_IDLE;
				end
			end
			adc_ctl_pkg::ST_PROC: begin
				if (pif.sample_valid) begin
					nxt_state = cont_ff ? adc_ctl_pkg::ST_PACE : adc_ctl_pkg::ST_IDLE;
				end
			end
			adc_ctl_pkg::ST_PACE: begin
				if (!cont_ff || (go && !cfg_ok)) begin
					nxt_state = adc_ctl_pkg::ST_IDLE;
				end else if (launch) begin
					nxt_state = ch_switch ? adc_ctl_pkg::ST_SETTLE : adc_ctl_pkg::ST_CONV;
				end
			end
			default: nxt_state = adc_ctl_pkg::ST_IDLE;
		endcase
	end

	// APB answer: one access cycle, no waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup & ~mapped;
			prdata_ff  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Software registers and interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff   <= '0;
			cont_ff  <= 1'b0;
			offs_ff  <= 16'h0000;
			imask_ff <= '0;
			istat_ff <= '0;
			irq_ff   <= 1'b0;
		end else begin
			if (wr & h_cfg)   cfg_ff   <= pwdata[adc_ctl_pkg::CFG_W-1:0];
			if (wr & h_ctrl)  cont_ff  <= pwdata[adc_ctl_pkg::CTRL_CONT];
			if (wr & h_offs)  offs_ff  <= pwdata[15:0];
			if (wr & h_imask) imask_ff <= pwdata[adc_ctl_pkg::IRQ_W-1:0];
			// Set wins over a same-cycle clear
			istat_ff <= (istat_ff & ~w1c) | ev;
			irq_ff   <= |(istat_ff & imask_ff);
		end
	end

	// Core synchronisers; raw word is stable long before done reaches us
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_s1_ff <= 1'b0;
			done_s2_ff <= 1'b0;
			done_d_ff  <= 1'b0;
			raw_s1_ff  <= 16'h0000;
			raw_s2_ff  <= 16'h0000;
		end else begin
			done_s1_ff <= core_done;
			done_s2_ff <= done_s1_ff;
			done_d_ff  <= done_s2_ff;
			raw_s1_ff  <= core_raw;
			raw_s2_ff  <= raw_s1_ff;
		end
	end

	// Sequencer state, latched settings and core selections
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff      <= adc_ctl_pkg::ST_IDLE;
			cur_chan_ff   <= 4'h0;
			cur_alt_ff    <= 1'b0;
			cur_range_ff  <= 2'h0;
			cur_ref_ff    <= 1'b0;
			cur_mode_ff   <= 3'h0;
			chan_known_ff <= 1'b0;
			core_start_ff <= 1'b0;
			gap_ff        <= '0;
		end else begin
			state_ff      <= nxt_state;
			core_start_ff <= enter_cv;
			if (launch) begin
				cur_chan_ff   <= cfg_chan;
				cur_alt_ff    <= cfg_ff[adc_ctl_pkg::CFG_ALT];
				cur_range_ff  <= cfg_range;
				cur_ref_ff    <= cfg_ff[adc_ctl_pkg::CFG_REF];
				cur_mode_ff   <= cfg_mode;
				chan_known_ff <= 1'b1;
			end
			if (enter_cv) begin
				gap_ff <= adc_ctl_pkg::CNT_W'(1);
			end else if (gap_ff != '1) begin
				gap_ff <= gap_ff + 1'b1;
			end
		end
	end

	// Result holding: valid set wins over a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_ff   <= 16'h0000;
			valid_ff  <= 1'b0;
			unread_ff <= 1'b0;
		end else begin
			if (result) begin
				data_ff  <= pif.sample;
				valid_ff <= 1'b1;
			end else if (data_rd || enter_cv) begin
				valid_ff <= 1'b0;
			end
			// Restart clears valid, so overrun needs its own unread memory
			unread_ff <= result | (unread_ff & ~data_rd);
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;
	// One select bit per pair, so both pins can never be routed together
	assign core_chan_sel    = cur_chan_ff;
	assign core_pin_alt     = cur_alt_ff & adc_ctl_pkg::DUAL_MASK[cur_chan_ff];
	assign core_range       = cur_range_ff;
	assign core_ref_bandgap = cur_ref_ff;
	assign core_mode        = cur_mode_ff;
	assign core_start       = core_start_ff;

	// Checks
	logic [adc_ctl_pkg::CNT_W-1:0] settle_len_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_len_ff <= '0;
		end else begin
			settle_len_ff <= (state_ff == adc_ctl_pkg::ST_SETTLE) ? settle_len_ff + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_sample_16;
		result |=> (data_ff == $past(pif.sample)) && valid_ff;
	endproperty
	a_sample_16: assert property (p_sample_16) else $error("sample word not captured");

	property p_chan_legal;
		core_start |-> core_chan_sel < 4'(adc_ctl_pkg::NUM_CH);
	endproperty
	a_chan_legal: assert property (p_chan_legal) else $error("illegal channel converted");

	property p_conv_bound;
		$rose(core_start) |-> ##[1:CONV_LIM] (state_ff != adc_ctl_pkg::ST_CONV);
	endproperty
	a_conv_bound: assert property (p_conv_bound) else $error("conversion overran its time");

	property p_ref_follow;
		launch |=> core_ref_bandgap == $past(cfg_ff[adc_ctl_pkg::CFG_REF]);
	endproperty
	a_ref_follow: assert property (p_ref_follow) else $error("reference select not applied");

	property p_proc_path;
		pif.raw_valid |=> pif.sample_valid ##1 valid_ff;
	endproperty
	a_proc_path: assert property (p_proc_path) else $error("raw sample not processed");

	property p_range_legal;
		core_range != adc_ctl_pkg::RANGE_BAD;
	endproperty
	a_range_legal: assert property (p_range_legal) else $error("illegal input range driven");

	property p_pace;
		(core_start && cont_ff && $past(state_ff) == adc_ctl_pkg::ST_PACE) |-> $past(gap_ff) >= adc_ctl_pkg::per_cyc(core_mode);
	endproperty
	a_pace: assert property (p_pace) else $error("sample rate above mode maximum");

	property p_settle;
		(state_ff == adc_ctl_pkg::ST_SETTLE && nxt_state == adc_ctl_pkg::ST_CONV)
			|-> settle_len_ff >= adc_ctl_pkg::lat_cyc(cur_mode_ff);
	endproperty
	a_settle: assert property (p_settle) else $error("settling latency too short");

	property p_hold;
		(valid_ff && !data_rd && !enter_cv && !result) |=> valid_ff && $stable(data_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("held sample disturbed");

	c_single: cover property (sw_start ##[1:400] result);
	c_settle: cover property ((state_ff == adc_ctl_pkg::ST_SETTLE) && (nxt_state == adc_ctl_pkg::ST_CONV)
		##[1:300] result);
	c_tmo:    cover property (conv_tmo);
	c_irq:    cover property ($rose(irq));
endmodule : adc_digital_control

/* dv/adc_core_model.sv */
`timescale 1ns/100ps
module adc_core_model (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Selections from the control logic
	input wire logic [3:0]  core_chan_sel,
	input wire logic        core_pin_alt,
	input wire logic [1:0]  core_range,
	input wire logic        core_ref_bandgap,
	input wire logic [2:0]  core_mode,
	input wire logic        core_start,
	// Bench knobs
	input wire logic [7:0]  ans_cyc,
	input wire logic        mute,
	// Result
	output logic            core_done,
	output logic [15:0]     core_raw
);
	logic       busy_ff;
	logic [7:0] cnt_ff;

	// Raw word mirrors the selections so routing errors show in the sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff   <= 1'b0;
			cnt_ff    <= 8'h00;
			core_done <= 1'b0;
			core_raw  <= 16'h0000;
		end else if (core_start) begin
			busy_ff   <= 1'b1;
			cnt_ff    <= ans_cyc;
			core_done <= 1'b0;
			core_raw  <= ~core_raw; // Stale word is not left looking valid
		end else if (mute) begin
			busy_ff <= 1'b0;
		end else if (busy_ff) begin
			if (cnt_ff == 8'h01)
				core_raw <= {core_chan_sel, core_pin_alt, core_mode, core_range, core_ref_bandgap, 5'h15};
			if (cnt_ff == 8'h00) begin
				core_done <= 1'b1;
				busy_ff   <= 1'b0;
			end else begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule : adc_core_model

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [3:0]  core_chan_sel;
	logic        core_pin_alt;
	logic [1:0]  core_range;
	logic        core_ref_bandgap;
	logic [2:0]  core_mode;
	logic        core_start;
	logic        core_done;
	logic [15:0] core_raw;
	logic [7:0]  ans_cyc;
	logic        mute;
	logic [10:0] snap;
	int          errors;
	int          cmp_count;
	int          cyc;
	int          st_cyc;
	int          st_n;
	int          wr_cyc;
	int          lat_t [5] = '{adc_ctl_pkg::LAT_CYC_M0, adc_ctl_pkg::LAT_CYC_M1, adc_ctl_pkg::LAT_CYC_M2,
		adc_ctl_pkg::LAT_CYC_M3, adc_ctl_pkg::LAT_CYC_M4};

	adc_digital_control adc_digital_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .core_chan_sel(core_chan_sel), .core_pin_alt(core_pin_alt), .core_range(core_range),
		.core_ref_bandgap(core_ref_bandgap), .core_mode(core_mode), .core_start(core_start),
		.core_done(core_done), .core_raw(core_raw));

	adc_core_model adc_core_model_inst (.pclk(pclk), .presetn(presetn), .core_chan_sel(core_chan_sel),
		.core_pin_alt(core_pin_alt), .core_range(core_range), .core_ref_bandgap(core_ref_bandgap),
		.core_mode(core_mode), .core_start(core_start), .ans_cyc(ans_cyc), .mute(mute),
		.core_done(core_done), .core_raw(core_raw));

	always #25 pclk = ~pclk;

	// Launch monitor: cycle and selections at each start pulse
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (core_start === 1'b1) begin
			st_cyc <= cyc;
			st_n   <= st_n + 1;
			snap   <= {core_chan_sel, core_pin_alt, core_range, core_ref_bandgap, core_mode};
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One transfer; a spare cycle before setup keeps drives one per time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		wr_cyc = cyc;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(n < 20), 32'h1);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd

	task automatic poll_ist(input logic [31:0] bits);
		logic [31:0] q;
		int          n;
		n = 0;
		do begin
			rd(adc_ctl_pkg::OFF_ISTAT, q);
			n++;
		end while ((q & bits) !== bits && n < 1000);
		chk("istat bits", q & bits, bits);
	endtask : poll_ist

	task automatic run_conv(input logic [10:0] cfg, input logic [15:0] offs, input logic settle);
		logic [31:0] q;
		logic [15:0] raw;
		logic [3:0]  ch;
		logic        alt;
		int          n;
		int          t0;
		int          d;
		ch  = cfg[3:0];
		alt = cfg[4] & adc_ctl_pkg::DUAL_MASK[ch];
		raw = {ch, alt, cfg[10:8], cfg[6:5], cfg[7], 5'h15};
		wr(adc_ctl_pkg::OFF_OFFS, {16'h0, offs});
		wr(adc_ctl_pkg::OFF_CFG, {21'h0, cfg});
		n = st_n;
		wr(adc_ctl_pkg::OFF_CTRL, 32'h1);
		t0 = wr_cyc;
		for (int i = 0; i < 4000 && st_n == n; i++)
			@(negedge pclk);
		d = st_cyc - t0;
		if (settle)
			chk("settle span", 32'(d >= lat_t[cfg[10:8]] && d <= lat_t[cfg[10:8]] + 8), 32'h1);
		else
			chk("no resettle", 32'(d <= 8), 32'h1);
		chk("core selections", {21'h0, snap}, {21'h0, ch, alt, cfg[6:5], cfg[7], cfg[10:8]});
		for (int i = 0; i < 400 && irq !== 1'b1; i++)
			@(negedge pclk);
		chk("conversion time", 32'(cyc - st_cyc <= adc_ctl_pkg::CONV_CYC), 32'h1);
		rd(adc_ctl_pkg::OFF_DATA, q);
		chk("sample", q, {16'h0, (raw > offs) ? raw - offs : 16'h0});
		rd(adc_ctl_pkg::OFF_STAT, q);
		chk("valid after read", {31'h0, q[0]}, 32'h0);
		chk("stat channel", {28'h0, q[7:4]}, {28'h0, ch});
		wr(adc_ctl_pkg::OFF_ISTAT, 32'hF);
	endtask : run_conv

	task automatic t_reset_vals();
		logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
		logic [31:0] q;
		logic        e;
		foreach (offs[i]) begin
			rd(offs[i], q);
			chk("reset value", q, 32'h0);
		end
		apb(1'b0, 8'h1C, 32'h0, q, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", q, 32'h0);
		chk("irq idle", {31'h0, irq}, 32'h0);
		$display("t_reset_vals done");
	endtask : t_reset_vals

	// Every channel, mode and range at least once, alternate pin always requested, reference toggled per run
	task automatic t_channels();
		wr(adc_ctl_pkg::OFF_IMASK, 32'h1);
		for (int i = 0; i < 9; i++)
			run_conv({3'(i % 5), i[0], 2'(i % 3), 1'b1, 4'(i)}, 16'h0000, 1'b1);
		$display("t_channels done");
	endtask : t_channels

	task automatic t_resample();
		run_conv(11'h358, 16'h0010, 1'b0);
		run_conv(11'h358, 16'hFFFF, 1'b0);
		$display("t_resample done");
	endtask : t_resample

	task automatic t_irq_ovr();
		logic [31:0] q;
		wr(adc_ctl_pkg::OFF_IMASK, 32'h0);
		wr(adc_ctl_pkg::OFF_CTRL, 32'h1);
		poll_ist(32'h1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(adc_ctl_pkg::OFF_CTRL, 32'h1);
		poll_ist(32'h3);
		wr(adc_ctl_pkg::OFF_IMASK, 32'h2);
		repeat (3) @(negedge pclk);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(adc_ctl_pkg::OFF_ISTAT, 32'hF);
		repeat (3) @(negedge pclk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rd(adc_ctl_pkg::OFF_DATA, q);
		$display("t_irq_ovr done");
	endtask : t_irq_ovr

	// Silent core must not hang the block
	task automatic t_timeout();
		logic [31:0] q;
		mute <= 1'b1;
		wr(adc_ctl_pkg::OFF_CTRL, 32'h1);
		poll_ist(32'h4);
		rd(adc_ctl_pkg::OFF_STAT, q);
		chk("busy after timeout", {31'h0, q[1]}, 32'h0);
		mute <= 1'b0;
		wr(adc_ctl_pkg::OFF_ISTAT, 32'hF);
		$display("t_timeout done");
	endtask : t_timeout

	task automatic t_cfg_err();
		logic [10:0] bad [3] = '{11'h009, 11'h061, 11'h501};
		int          n;
		foreach (bad[i]) begin
			n = st_n;
			wr(adc_ctl_pkg::OFF_CFG, {21'h0, bad[i]});
			wr(adc_ctl_pkg::OFF_CTRL, 32'h1);
			poll_ist(32'h8);
			chk("no launch", 32'(st_n), 32'(n));
			wr(adc_ctl_pkg::OFF_ISTAT, 32'hF);
		end
		$display("t_cfg_err done");
	endtask : t_cfg_err

	// Continuous mode: starts paced at the mode's period, unread result flags overrun
	task automatic t_cont();
		logic [31:0] q;
		int          n;
		int          t1;
		wr(adc_ctl_pkg::OFF_CFG, 32'h400);
		n = st_n;
		wr(adc_ctl_pkg::OFF_CTRL, 32'h3);
		for (int i = 0; i < 2000 && st_n == n; i++)
			@(negedge pclk);
		t1 = st_cyc;
		for (int i = 0; i < 2000 && st_n == n + 1; i++)
			@(negedge pclk);
		t1 = st_cyc - t1;
		chk("pace span", 32'(t1 >= adc_ctl_pkg::PER_CYC_M4 && t1 <= adc_ctl_pkg::PER_CYC_M4 + 8), 32'h1);
		poll_ist(32'h3);
		wr(adc_ctl_pkg::OFF_CTRL, 32'h0);
		repeat (300) @(negedge pclk);
		rd(adc_ctl_pkg::OFF_STAT, q);
		chk("busy after stop", {31'h0, q[1]}, 32'h0);
		rd(adc_ctl_pkg::OFF_DATA, q);
		wr(adc_ctl_pkg::OFF_ISTAT, 32'hF);
		$display("t_cont done");
	endtask : t_cont

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	initial begin
		#3_000_000;
		errors++;
		$display("[ERR] watchdog expected finish seen hang");
		final_report();
	end

	initial begin
		pclk    = 1'b0;
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		ans_cyc = 8'h14;
		mute    = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_vals();
		t_channels();
		t_resample();
		t_irq_ovr();
		t_timeout();
		t_cfg_err();
		t_cont();
		final_report();
	end
endmodule : tb_top
